// ### hdl/epv_pkg.sv
/*
 Shared constants for the EPROM program and verify port: mode codes, address widths,
 pulse counts and timing counts in crystal clock cycles.
 Assumes both ends run on one system clock; the crystal clock is a pin-rate enable.
*/
// Contract
// - Programmer holds reset high two machine cycles.
// - Programmer drives pulse and voltage pins high first.
// - Ten-bit mode code, LSB first, on reset.
// - Sample while clock high; change while low.
// - Reset stays low after the code.
// - Eleven-bit address over one eight-bit port.
// - Half select high at least 13 clocks.
// - High part latched on select fall, held 2.
// - Low byte stable 13 clocks after applied.
// - High address part retained across operations.
// - Auxiliary port output until voltage applied.
// - Programmer issues 25 pulses, pin ends high.
// - Data port input in program, output verify.
// - Verify data appears 48 clocks after voltage drop.
// - Each byte repeats address, program, verify.
// - Addresses 30H and 31H return identification bytes.
// - 286H program/verify, 280H identification read.
// - Erased array reads all ones.
package epv_pkg;
   localparam int EPV_CODE_BITS = 10;
   localparam logic [9:0] EPV_CODE_USER = 10'h286;
   localparam logic [9:0] EPV_CODE_IDENT = 10'h280;
   localparam int EPV_ADDR_BITS = 11;
   localparam int EPV_HIGH_BITS = 3;
   localparam int EPV_MEM_DEPTH = 2048;
   localparam logic [10:0] EPV_IDENT_ADDR0 = 11'h030;
   localparam logic [10:0] EPV_IDENT_ADDR1 = 11'h031;
   localparam logic [7:0] EPV_IDENT_CODE0 = 8'hA5; // Arbitrary value.
   localparam logic [7:0] EPV_IDENT_CODE1 = 8'h5A; // Arbitrary value.
   localparam logic [7:0] EPV_ERASED = 8'hFF;
   localparam int EPV_PULSES = 25;
   localparam int EPV_RESET_CLKS = 24; // Two machine cycles of twelve clocks.
   localparam int EPV_SELECT_CLKS = 13;
   localparam int EPV_HOLD_CLKS = 2;
   localparam int EPV_STABLE_CLKS = 13;
   localparam int EPV_VERIFY_CLKS = 48;
   localparam int EPV_PULSE_CLKS = 2; // Pulse phase length in crystal periods, kept short.
   localparam int EPV_XTAL_DIV = 17; // System clocks per crystal half period, under 6 MHz.
   localparam int EPV_SYS_NS = 5;
endpackage

// ### hdl/epv_link_if.sv
/*
 Pin set between the device end and the programmer end.
 Assumes a single system clock; the crystal clock pin is a plain level.
*/
`timescale 1ns/1ps
interface epv_link_if;
   logic xtal;
   logic rst_pin;
   logic address_half_select;
   logic [7:0] addr_port;
   logic vpp_high;
   logic vpp_logic;
   logic program_pulse_pin_pin;
   logic [7:0] data_dev;
   logic data_dev_oe;
   logic [7:0] data_prg;
   logic data_prg_oe;
   logic aux_oe;
   modport device(input xtal, rst_pin, address_half_select, addr_port, vpp_high, vpp_logic, program_pulse_pin_pin,
      data_prg, data_prg_oe, output data_dev, data_dev_oe, aux_oe);
   modport programmer(output xtal, rst_pin, address_half_select, addr_port, vpp_high, vpp_logic, program_pulse_pin_pin,
      data_prg, data_prg_oe, input data_dev, data_dev_oe, aux_oe);
endinterface

// ### hdl/epv_device.sv
/*
 Device end: mode code receiver, multiplexed address latch, pulse-counted byte
 programming and delayed verify read-out over the data port.
 Assumes the programmer end drives the pins; inputs from pins pass three flops, except the data port, which is written to the array directly.
*/
`timescale 1ns/1ps
module epv_device
   import epv_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   epv_link_if.device link,
   output logic o_program_pulse_pin_mode,
   output logic o_ident_mode
);
   typedef enum logic [1:0] {
      EPV_ST_NORMAL = 2'b00,
      EPV_ST_SHIFT = 2'b01,
      EPV_ST_ACTIVE = 2'b10
   } epv_state_type;

   logic [7:0] mem [0:EPV_MEM_DEPTH-1];
   logic [7:0] fill_reg;
   logic [2:0] s_xt, s_rs, s_as, s_vh, s_vl, s_pg;
   logic [7:0] a1_reg, a2_reg, a3_reg;
   epv_state_type st_reg, st_next;
   logic [9:0] sh_reg, sh_next;
   logic [3:0] nb_reg, nb_next;
   logic [2:0] hi_reg, hi_next;
   logic [7:0] lo_reg, lo_next;
   logic [7:0] lcnt_reg, lcnt_next;
   logic lstb_reg, lstb_next;
   logic [4:0] pc_reg, pc_next;
   logic [5:0] vc_reg, vc_next;
   logic id_reg, id_next;
   logic [7:0] dout_reg, dout_next;
   logic doe_reg, doe_next;
   logic aux_reg, aux_next;
   logic [4:0] rh_reg, rh_next;
   logic wr;
   logic [10:0] addr;
   logic xt_rise, as_fall, pg_rise, vl_fall;

   // Three-stage synchronisers; edges seen where stages two and three disagree.
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_xt <= 3'h0; s_rs <= 3'h0; s_as <= 3'h0;
         s_vh <= 3'h0; s_vl <= 3'h7; s_pg <= 3'h7;
         a1_reg <= 8'h00; a2_reg <= 8'h00; a3_reg <= 8'h00;
      end else begin
         s_xt <= {s_xt[1:0], link.xtal};
         s_rs <= {s_rs[1:0], link.rst_pin};
         s_as <= {s_as[1:0], link.address_half_select};
         s_vh <= {s_vh[1:0], link.vpp_high};
         s_vl <= {s_vl[1:0], link.vpp_logic};
         s_pg <= {s_pg[1:0], link.program_pulse_pin_pin};
         a1_reg <= link.addr_port;
         a2_reg <= a1_reg;
         a3_reg <= a2_reg;
      end
   end
   assign xt_rise = s_xt[1] & ~s_xt[2];
   assign as_fall = ~s_as[1] & s_as[2];
   assign pg_rise = s_pg[1] & ~s_pg[2];
   assign vl_fall = ~s_vh[1] & s_vh[2];
   assign addr = {hi_reg, lo_reg};

   // Mode, address, programming and verify sequencing.
   always_comb begin
      st_next = st_reg; sh_next = sh_reg; nb_next = nb_reg;
      hi_next = hi_reg; lo_next = lo_reg; lcnt_next = lcnt_reg; lstb_next = lstb_reg;
      pc_next = pc_reg; vc_next = vc_reg; id_next = id_reg;
      dout_next = dout_reg; doe_next = doe_reg; aux_next = aux_reg;
      rh_next = rh_reg;
      wr = 1'b0;
      // Reset high for a machine cycle restarts reception; code bits never stay high that long.
      if (!s_rs[2]) begin
         rh_next = 5'h00;
      end else if (xt_rise && rh_reg != 5'(EPV_RESET_CLKS / 2)) begin
         rh_next = rh_reg + 5'h01;
      end
      if (s_rs[2] && rh_reg == 5'(EPV_RESET_CLKS / 2)) begin
         st_next = EPV_ST_SHIFT;
         nb_next = 4'h0;
         vc_next = 6'h00;
         doe_next = 1'b0;
         aux_next = 1'b0;
      end else case (st_reg)
         EPV_ST_SHIFT: begin
            if (xt_rise) begin
               sh_next = {s_rs[2], sh_reg[9:1]};
               nb_next = nb_reg + 4'h1;
               if (nb_reg == 4'(EPV_CODE_BITS - 1)) begin
                  if ({s_rs[2], sh_reg[9:1]} == EPV_CODE_USER) begin
                     st_next = EPV_ST_ACTIVE; id_next = 1'b0; aux_next = 1'b1;
                  end else if ({s_rs[2], sh_reg[9:1]} == EPV_CODE_IDENT) begin
                     st_next = EPV_ST_ACTIVE; id_next = 1'b1; aux_next = 1'b1;
                  end else begin
                     st_next = EPV_ST_NORMAL;
                  end
               end
            end
         end
         EPV_ST_ACTIVE: begin
            if (s_as[2] && s_as[1]) begin
               lstb_next = 1'b0;
            end
            if (as_fall) begin
               hi_next = a3_reg[2:0];
            end
            // Low byte stands only after it is unchanged for a full window.
            if (a3_reg != a2_reg || s_as[2]) begin
               lcnt_next = 8'h00; lstb_next = 1'b0;
            end else if (xt_rise && !lstb_reg) begin
               lcnt_next = lcnt_reg + 8'h01;
               if (lcnt_reg == 8'(EPV_STABLE_CLKS - 1)) begin
                  lo_next = a3_reg; lstb_next = 1'b1;
               end
            end
            if (s_vh[2]) begin
               aux_next = 1'b0;
               doe_next = 1'b0;
               vc_next = 6'h00;
               if (pg_rise && !id_reg && lstb_reg) begin
                  if (pc_reg == 5'(EPV_PULSES - 1)) begin
                     pc_next = 5'h00; wr = 1'b1;
                  end else begin
                     pc_next = pc_reg + 5'h01;
                  end
               end
            end else begin
               pc_next = 5'h00;
               if (vl_fall) begin
                  vc_next = 6'h00; doe_next = 1'b0;
               end else if (xt_rise && vc_reg != 6'(EPV_VERIFY_CLKS)) begin
                  vc_next = vc_reg + 6'h01;
               end
               if (vc_reg == 6'(EPV_VERIFY_CLKS) && s_vl[2]) begin
                  doe_next = 1'b1;
                  if (id_reg) begin
                     dout_next = (addr == EPV_IDENT_ADDR0) ? EPV_IDENT_CODE0 :
                        (addr == EPV_IDENT_ADDR1) ? EPV_IDENT_CODE1 : EPV_ERASED;
                  end else begin
                     dout_next = fill_reg[0] ? mem[addr] : EPV_ERASED;
                  end
               end
            end
         end
         default: begin
            st_next = EPV_ST_NORMAL;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= EPV_ST_NORMAL;
         sh_reg <= 10'h000;
         nb_reg <= 4'h0;
         hi_reg <= 3'h0;
         lo_reg <= 8'h00;
         lcnt_reg <= 8'h00;
         lstb_reg <= 1'b0;
         pc_reg <= 5'h00;
         vc_reg <= 6'h00;
         id_reg <= 1'b0;
         dout_reg <= 8'h00;
         doe_reg <= 1'b0;
         aux_reg <= 1'b0;
         rh_reg <= 5'h00;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         nb_reg <= nb_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         lcnt_reg <= lcnt_next;
         lstb_reg <= lstb_next;
         pc_reg <= pc_next;
         vc_reg <= vc_next;
         id_reg <= id_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
         aux_reg <= aux_next;
         rh_reg <= rh_next;
      end
   end

   // Array cells; a cell never written reads as erased through the fill mark.
   logic [EPV_MEM_DEPTH-1:0] written_reg;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         written_reg <= '0;
      end else if (wr) begin
         written_reg[addr] <= 1'b1;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (wr) begin
         mem[addr] <= link.data_prg;
      end
   end
   assign fill_reg = {7'h00, written_reg[addr]};

   assign link.data_dev = dout_reg;
   assign link.data_dev_oe = doe_reg;
   assign link.aux_oe = aux_reg;

   // Mode flags registered from the next state and next identification flag, in step with the state register.
   logic pm_reg, im_reg;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pm_reg <= 1'b0; im_reg <= 1'b0;
      end else begin
         pm_reg <= (st_next == EPV_ST_ACTIVE) && !id_next;
         im_reg <= (st_next == EPV_ST_ACTIVE) && id_next;
      end
   end
   assign o_program_pulse_pin_mode = pm_reg;
   assign o_ident_mode = im_reg;
endmodule

// ### hdl/epv_programmer.sv
/*
 Programmer end: runs the reset, mode code, address load, pulse train and
 verify sequence for one byte per user command.
 Assumes the device end answers on the same system clock; inputs pass three flops.
*/
`timescale 1ns/1ps
module epv_programmer
   import epv_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   epv_link_if.programmer link,
   input wire logic i_start,
   input wire logic i_ident,
   input wire logic i_write,
   input wire logic [10:0] i_addr,
   input wire logic [7:0] i_data,
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_rdata
);
   typedef enum logic [3:0] {
      EPV_P_IDLE = 4'h0, EPV_P_RST = 4'h1, EPV_P_CODE = 4'h2, EPV_P_ADDRESS_HALF_SELECT = 4'h3,
      EPV_P_AHOLD = 4'h4, EPV_P_ALOW = 4'h5, EPV_P_VPP = 4'h6, EPV_P_PULSE = 4'h7,
      EPV_P_VER = 4'h8, EPV_P_DONE = 4'h9
   } epv_pstate_type;

   epv_pstate_type st_reg, st_next;
   logic [6:0] div_reg, div_next;
   logic xt_reg, xt_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [5:0] pc_reg, pc_next;
   logic [9:0] code_reg, code_next;
   logic rst_reg, rst_next, address_half_select_reg, address_half_select_next, vh_reg, vh_next, pg_reg, pg_next;
   logic [7:0] ap_reg, ap_next, rd_reg, rd_next;
   logic busy_reg, busy_next, done_reg, done_next, wr_reg, wr_next, doe_reg, doe_next;
   logic [10:0] a_reg, a_next;
   logic [7:0] d_reg, d_next;
   logic [2:0] s_oe;
   logic [7:0] s1_d, s2_d, s3_d;
   logic fall_tick;

   // Samples the device data port through three stages.
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_oe <= 3'h0; s1_d <= 8'h00; s2_d <= 8'h00; s3_d <= 8'h00;
      end else begin
         s_oe <= {s_oe[1:0], link.data_dev_oe};
         s1_d <= link.data_dev; s2_d <= s1_d; s3_d <= s2_d;
      end
   end
   assign fall_tick = (div_reg == 7'(EPV_XTAL_DIV - 1)) && xt_reg;

   // Crystal clock divider and the session sequence.
   always_comb begin
      div_next = (div_reg == 7'(EPV_XTAL_DIV - 1)) ? 7'h00 : div_reg + 7'h01;
      xt_next = (div_reg == 7'(EPV_XTAL_DIV - 1)) ? ~xt_reg : xt_reg;
      st_next = st_reg; cnt_next = cnt_reg; pc_next = pc_reg; code_next = code_reg;
      rst_next = rst_reg; address_half_select_next = address_half_select_reg; vh_next = vh_reg; pg_next = pg_reg;
      ap_next = ap_reg; rd_next = rd_reg; busy_next = busy_reg; done_next = 1'b0;
      wr_next = wr_reg; doe_next = doe_reg; a_next = a_reg; d_next = d_reg;
      case (st_reg)
         EPV_P_IDLE: if (i_start) begin
            busy_next = 1'b1; wr_next = i_write; a_next = i_addr; d_next = i_data;
            code_next = i_ident ? EPV_CODE_IDENT : EPV_CODE_USER;
            rst_next = 1'b1; pg_next = 1'b1; vh_next = 1'b0;
            cnt_next = 8'h00; st_next = EPV_P_RST;
         end
         EPV_P_RST: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_RESET_CLKS)) begin
               rst_next = code_reg[0]; code_next = code_reg >> 1;
               cnt_next = 8'h01; st_next = EPV_P_CODE;
            end
         end
         EPV_P_CODE: if (fall_tick) begin
            if (cnt_reg == 8'(EPV_CODE_BITS)) begin
               rst_next = 1'b0;
               address_half_select_next = 1'b1; ap_next = {5'h00, a_reg[10:8]};
               cnt_next = 8'h00; st_next = EPV_P_ADDRESS_HALF_SELECT;
            end else begin
               rst_next = code_reg[0]; code_next = code_reg >> 1;
               cnt_next = cnt_reg + 8'h01;
            end
         end
         EPV_P_ADDRESS_HALF_SELECT: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_SELECT_CLKS)) begin
               address_half_select_next = 1'b0; cnt_next = 8'h00; st_next = EPV_P_AHOLD;
            end
         end
         EPV_P_AHOLD: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_HOLD_CLKS)) begin
               ap_next = a_reg[7:0]; cnt_next = 8'h00; st_next = EPV_P_ALOW;
            end
         end
         EPV_P_ALOW: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_STABLE_CLKS + 2)) begin
               cnt_next = 8'h00; pc_next = 6'h00;
               if (wr_reg) begin
                  vh_next = 1'b1; doe_next = 1'b1; st_next = EPV_P_VPP;
               end else begin
                  st_next = EPV_P_VER;
               end
            end
         end
         EPV_P_VPP: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_PULSE_CLKS)) begin
               cnt_next = 8'h00;
               if (pc_reg == 6'(EPV_PULSES)) begin
                  vh_next = 1'b0; doe_next = 1'b0; st_next = EPV_P_VER;
               end else begin
                  pg_next = 1'b0; st_next = EPV_P_PULSE;
               end
            end
         end
         EPV_P_PULSE: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_PULSE_CLKS)) begin
               pg_next = 1'b1; pc_next = pc_reg + 6'h01; cnt_next = 8'h00;
               st_next = EPV_P_VPP;
            end
         end
         EPV_P_VER: if (fall_tick) begin
            cnt_next = cnt_reg + 8'h01;
            if (cnt_reg == 8'(EPV_VERIFY_CLKS + 4) && s_oe[2]) begin
               rd_next = s3_d; st_next = EPV_P_DONE;
            end
         end
         EPV_P_DONE: begin
            busy_next = 1'b0; done_next = 1'b1; st_next = EPV_P_IDLE;
         end
         default: st_next = EPV_P_IDLE;
      endcase
   end

   // Sequence registers.
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= EPV_P_IDLE; div_reg <= 7'h00; xt_reg <= 1'b0; cnt_reg <= 8'h00;
         pc_reg <= 6'h00; code_reg <= 10'h000; rst_reg <= 1'b0; address_half_select_reg <= 1'b0;
         vh_reg <= 1'b0; pg_reg <= 1'b1; ap_reg <= 8'h00; rd_reg <= 8'h00;
         busy_reg <= 1'b0; done_reg <= 1'b0; wr_reg <= 1'b0; doe_reg <= 1'b0;
         a_reg <= 11'h000; d_reg <= 8'h00;
      end else begin
         st_reg <= st_next; div_reg <= div_next; xt_reg <= xt_next; cnt_reg <= cnt_next;
         pc_reg <= pc_next; code_reg <= code_next; rst_reg <= rst_next;
         address_half_select_reg <= address_half_select_next; vh_reg <= vh_next; pg_reg <= pg_next; ap_reg <= ap_next;
         rd_reg <= rd_next; busy_reg <= busy_next; done_reg <= done_next;
         wr_reg <= wr_next; doe_reg <= doe_next; a_reg <= a_next; d_reg <= d_next;
      end
   end

   assign link.xtal = xt_reg;
   assign link.rst_pin = rst_reg;
   assign link.address_half_select = address_half_select_reg;
   assign link.addr_port = ap_reg;
   assign link.vpp_high = vh_reg;
   assign link.vpp_logic = ~vh_reg;
   assign link.program_pulse_pin_pin = pg_reg;
   assign link.data_prg = d_reg;
   assign link.data_prg_oe = doe_reg;
   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_rdata = rd_reg;
endmodule

// ### bench/epv_link_asserts.sv
/*
 Concurrent checks on the pins between the device end and the programmer end.
 Assumes one system clock and the shared active-low asynchronous reset.
*/
`timescale 1ns/1ps
module epv_link_asserts (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic xtal,
   input wire logic rst_pin,
   input wire logic address_half_select,
   input wire logic [7:0] addr_port,
   input wire logic vpp_high,
   input wire logic vpp_logic,
   input wire logic program_pulse_pin_pin,
   input wire logic [7:0] data_dev,
   input wire logic data_dev_oe,
   input wire logic [7:0] data_prg,
   input wire logic data_prg_oe,
   input wire logic aux_oe
);
   logic xtal_d_reg;
   logic xrise;
   logic [7:0] hi_reg;
   logic [7:0] address_half_select_reg;
   logic [1:0] post_reg;
   logic [5:0] pulse_reg;
   logic [6:0] vpp_reg;
   logic [7:0] wdat_reg;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // Crystal rise seen on the system clock.
   assign xrise = xtal & ~xtal_d_reg;
   // Phase counters in crystal rises saturate so long phases cannot wrap; the pulse counter counts pulse falls and does not saturate.
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         xtal_d_reg <= 1'b0;
         hi_reg <= 8'h00;
         address_half_select_reg <= 8'h00;
         post_reg <= 2'h3;
         pulse_reg <= 6'h00;
         vpp_reg <= 7'h7F;
         wdat_reg <= 8'h00;
      end else begin
         xtal_d_reg <= xtal;
         hi_reg <= !rst_pin ? 8'h00 : (xrise && hi_reg != 8'hFF) ? hi_reg + 8'h01 : hi_reg;
         address_half_select_reg <= !address_half_select ? 8'h00 : (xrise && address_half_select_reg != 8'hFF) ? address_half_select_reg + 8'h01 : address_half_select_reg;
         post_reg <= $fell(address_half_select) ? 2'h0 : (xrise && post_reg != 2'h3) ? post_reg + 2'h1 : post_reg;
         pulse_reg <= !vpp_high ? 6'h00 : $fell(program_pulse_pin_pin) ? pulse_reg + 6'h01 : pulse_reg;
         vpp_reg <= $fell(vpp_high) ? 7'h00 : (xrise && vpp_reg != 7'h7F) ? vpp_reg + 7'h01 : vpp_reg;
         wdat_reg <= (vpp_high && $rose(program_pulse_pin_pin)) ? data_prg : wdat_reg;
      end
   end
   sequence s_pulse_end;
      $fell(vpp_high);
   endsequence
   sequence s_verify_due;
      vpp_reg == 7'd51;
   endsequence
   a_reset_hold_long: assert property ($fell(rst_pin) |-> hi_reg <= 8'd2 || hi_reg >= 8'd24)
      else $error("reset pin high phase too short");
   a_code_change_low: assert property ($fell(rst_pin) |-> !xtal)
      else $error("reset pin changed while crystal high");
   a_select_width: assert property ($fell(address_half_select) |-> address_half_select_reg >= 8'd13)
      else $error("half select high too short");
   a_high_part_hold: assert property ($changed(addr_port) |-> post_reg >= 2'd2)
      else $error("high address dropped too soon");
   a_pulse_total: assert property (s_pulse_end |-> pulse_reg == 6'd25 && program_pulse_pin_pin)
      else $error("pulse count wrong at voltage drop");
   a_pulse_in_vpp: assert property ($fell(program_pulse_pin_pin) |-> vpp_high && data_prg_oe)
      else $error("pulse without voltage or data");
   a_code_pins_high: assert property (rst_pin |-> program_pulse_pin_pin && vpp_logic && !vpp_high)
      else $error("pulse or voltage pin low during code");
   a_aux_to_input: assert property ($rose(vpp_high) |-> ##[1:200] !aux_oe)
      else $error("auxiliary port still driven");
   a_data_dir_program_pulse_pin: assert property (vpp_high && $past(vpp_high, 200) |-> !data_dev_oe)
      else $error("device drives data while programming");
   a_verify_byte_due: assert property (s_verify_due |-> data_dev_oe && data_dev == wdat_reg)
      else $error("verify byte not shown in time");
endmodule

// ### bench/eprom_program_verify_port_tb.sv
/*
 Self-checking bench: programmer end against device end over one link, and a
 second device end driven by the bench itself for mode code cases.
 Assumes a 200 MHz system clock and the design package constants.
*/
`timescale 1ns/1ps
module eprom_program_verify_port_tb
   import epv_pkg::*;
;
   typedef struct packed {
      logic ident;
      logic wr;
      logic [10:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } epv_row_type;
   localparam int LIMIT = 70000; // About half again the expected run length.
   logic i_clk_sys = 1'b0;
   logic i_reset_n = 1'b0;
   logic start = 1'b0;
   logic ident = 1'b0;
   logic write = 1'b0;
   logic [10:0] addr = 11'h000;
   logic [7:0] wdata = 8'h00;
   logic busy, done, program_pulse_pin_mode, ident_mode, program_pulse_pin_mode_2, ident_mode_2;
   logic [7:0] rdata;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   epv_row_type rows [6];
   epv_link_if link ();
   epv_link_if link_2 ();
   epv_device i_epv_device (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(link),
      .o_program_pulse_pin_mode(program_pulse_pin_mode), .o_ident_mode(ident_mode));
   epv_device i_epv_device_2 (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(link_2),
      .o_program_pulse_pin_mode(program_pulse_pin_mode_2), .o_ident_mode(ident_mode_2));
   epv_programmer i_epv_programmer (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(link),
      .i_start(start), .i_ident(ident), .i_write(write), .i_addr(addr), .i_data(wdata),
      .o_busy(busy), .o_done(done), .o_rdata(rdata));
   epv_link_asserts i_epv_link_asserts (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .xtal(link.xtal), .rst_pin(link.rst_pin), .address_half_select(link.address_half_select), .addr_port(link.addr_port),
      .vpp_high(link.vpp_high), .vpp_logic(link.vpp_logic), .program_pulse_pin_pin(link.program_pulse_pin_pin),
      .data_dev(link.data_dev), .data_dev_oe(link.data_dev_oe), .data_prg(link.data_prg),
      .data_prg_oe(link.data_prg_oe), .aux_oe(link.aux_oe));
   // System clock, 5 ns period.
   initial begin
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         $display("unexpected at %0t: run did not finish", $time);
         close_out();
      end
   end
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic launch(input epv_row_type r);
      @(posedge i_clk_sys);
      start <= 1'b1;
      ident <= r.ident;
      write <= r.wr;
      addr <= r.addr;
      wdata <= r.data;
      @(posedge i_clk_sys);
      start <= 1'b0;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk1(done, 1'b1);
   endtask
   task automatic run_row(input epv_row_type r);
      launch(r);
      wait_done();
      chk8(rdata, r.exp);
      chk1(ident_mode, r.ident);
      chk1(program_pulse_pin_mode, ~r.ident);
   endtask
   // Crystal periods on the second link, four system clocks per half period.
   task automatic xt(input int n);
      repeat (n) begin
         repeat (4) @(posedge i_clk_sys);
         link_2.xtal <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         link_2.xtal <= 1'b0;
      end
   endtask
   task automatic send_code(input logic [9:0] code);
      @(posedge i_clk_sys);
      link_2.rst_pin <= 1'b1;
      xt(30);
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk_sys);
         link_2.rst_pin <= code[i];
         xt(1);
      end
      @(posedge i_clk_sys);
      link_2.rst_pin <= 1'b0;
      xt(20);
   endtask
   // Main sequence: table rows, then refusal, mid-run reset and code cases.
   initial begin
      {link_2.xtal, link_2.rst_pin, link_2.address_half_select, link_2.vpp_high} = 4'h0;
      {link_2.vpp_logic, link_2.program_pulse_pin_pin, link_2.data_prg_oe} = 3'b110;
      link_2.addr_port = 8'h00;
      link_2.data_prg = 8'h00;
      rows[0] = '{1'b1, 1'b0, EPV_IDENT_ADDR0, 8'h00, EPV_IDENT_CODE0};
      rows[1] = '{1'b1, 1'b0, EPV_IDENT_ADDR1, 8'h00, EPV_IDENT_CODE1};
      rows[2] = '{1'b0, 1'b0, 11'h7FF, 8'h00, EPV_ERASED};
      rows[3] = '{1'b0, 1'b1, 11'h5A3, 8'h3C, 8'h3C};
      rows[4] = '{1'b0, 1'b0, 11'h5A3, 8'h00, 8'h3C};
      rows[5] = '{1'b0, 1'b0, 11'h0A3, 8'h00, EPV_ERASED};
      @(negedge i_clk_sys);
      chk1(busy, 1'b0);
      chk1(link.program_pulse_pin_pin, 1'b1);
      repeat (5) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      launch(rows[0]);
      repeat (100) @(posedge i_clk_sys);
      launch(rows[1]);
      chk1(busy, 1'b1);
      wait_done();
      chk8(rdata, EPV_IDENT_CODE0);
      repeat (300) begin
         @(negedge i_clk_sys);
         chk1(done, 1'b0);
      end
      launch('{1'b0, 1'b1, 11'h123, 8'h00, 8'h00});
      repeat (4000) @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      @(negedge i_clk_sys);
      chk1(program_pulse_pin_mode, 1'b0);
      chk1(link.vpp_logic, 1'b1);
      chk1(link.data_dev_oe, 1'b0);
      repeat (5) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      run_row('{1'b0, 1'b0, 11'h123, 8'h00, EPV_ERASED});
      send_code(10'h287);
      @(negedge i_clk_sys);
      chk1(program_pulse_pin_mode_2, 1'b0);
      chk1(ident_mode_2, 1'b0);
      chk1(link_2.aux_oe, 1'b0);
      send_code(EPV_CODE_IDENT);
      @(negedge i_clk_sys);
      chk1(ident_mode_2, 1'b1);
      chk1(program_pulse_pin_mode_2, 1'b0);
      close_out();
   end
endmodule
